// file: pkg/tx_app_consts.svh
// offsets, field positions, reset values and timing counts of the transmit application interface
`ifndef TX_APP_CONSTS_SVH
`define TX_APP_CONSTS_SVH

// register byte addresses
`define REG_CTRL        8'h00
`define REG_IRQ_STATUS  8'h04
`define REG_IRQ_CLEAR   8'h08
`define REG_IRQ_ENABLE  8'h0C
`define REG_LAST_STAT   8'h10

// control register fields
`define CTRL_W          3
`define CTRL_TX_EN      0
`define CTRL_FCS_EN     1
`define CTRL_HALF_DUP   2
`define CTRL_RESET      3'h3

// interrupt status, clear and enable fields
`define IRQ_W           4
`define IRQ_DONE        0
`define IRQ_DISCARD     1
`define IRQ_UNDERRUN    2
`define IRQ_PAUSE_SENT  3

// statistics vector layout
`define SV_W            31
`define SV_UNICAST      0
`define SV_MULTICAST    1
`define SV_BROADCAST    2
`define SV_BAD_FCS      3
`define SV_JUMBO        4
`define SV_UNDERRUN     5
`define SV_PAUSE        6
`define SV_VLAN         7
`define SV_BYTES_LO     8
`define SV_BYTES_HI     21
`define SV_DEFER        22
`define SV_XDEFER       23
`define SV_LATE_COL     24
`define SV_XCOL         25
`define SV_ECOL_LO      26
`define SV_ECOL_HI      29
`define SV_SHORT        30

// framing
`define PRE_BYTE        8'h55
`define SFD_BYTE        8'hD5
`define PRE_LAST        4'h7
`define FCS_LAST        4'h3
`define IFG_LAST        4'hB
`define MIN_FRAME       14'h003C
`define SLOT_BYTES      14'h0040
`define JUMBO_BYTES     14'h05EE
`define ECOL_MAX        4'hF
`define BYTE_ALL_ONES   8'hFF
`define VLAN_TAG_HI     8'h81
`define VLAN_TAG_LO     8'h00
`define VLAN_POS_HI     14'h000C
`define VLAN_POS_LO     14'h000D
`define DA_LAST         14'h0005
`define BOTH_BYTES      2'b11
`define CRC_INIT        32'hFFFF_FFFF
`define CRC_POLY        32'hEDB8_8320

// pause frame contents, 18 header bytes before padding
`define PAUSE_DA        48'h0180_C200_0001
`define PAUSE_TYPE      16'h8808
`define PAUSE_OPCODE    16'h0001
`define PAUSE_LAST      14'h0011

// timing
`define CLK_PERIOD_NS   10
`define DEFER_LIMIT_NS  30000
`define DEFER_CYCLES    (`DEFER_LIMIT_NS / `CLK_PERIOD_NS)
`define DEFER_W         12

`endif

// file: pkg/tx_app_pkg.sv
// types shared by the transmit application interface
package tx_app_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_DEFER,
      S_PREAM,
      S_DATA,
      S_PAD,
      S_FCS,
      S_IFG
   } tx_state_type;

endpackage : tx_app_pkg

// file: logic/tx_app_if.sv
// transmit application interface: fifo fetch, pause frames, gmii byte stream, statistics, registers
// ----------------------------------------------------------------------------
// Summary of operation
// - empty fifo during fetch drives transmit error
// - pause request sends a pause control frame
// - pause time input goes into pause frame
// - frame type input marks control or normal
// - statistics vector valid while qualifier high
// - one-cycle read request per fifo word
// - stat bits 0..2: unicast, multicast, broadcast
// - stat bits 3..7: fcs, jumbo, underrun, pause, vlan
// - stat bits 21..8 carry frame byte count
// - stat bits 22, 23: deferred, excessively deferred
// - stat bits 24, 25: late, excessive collisions
// - stat bits 29..26 count early collisions
// - stat bit 30: short frame, fcs off
// - one-cycle done pulse for error-free frames
// - byte enable not both marks last word
// - discard pulse on underrun or collision errors
// ----------------------------------------------------------------------------
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "tx_app_consts.svh"

module tx_app_if #(
   parameter logic [47:0] SRC_MAC = 48'h0000_0000_0001  // arbitrary station address for pause frames
) (
   input  logic        mclk,
   input  logic        rst_n,
   input  logic [15:0] fifo_data,
   input  logic [1:0]  fifo_byte_en,
   input  logic        fifo_avail,
   input  logic        fifo_eof,
   input  logic        fifo_empty,
   input  logic        fifo_ctrl,
   input  logic        pause_req,
   input  logic [15:0] pause_time,
   output logic        fifo_read,
   output logic [30:0] stat_vec,
   output logic        stat_valid,
   output logic        tx_done,
   output logic        discard,
   output logic [7:0]  gmii_txd,
   output logic        gmii_tx_en,
   output logic        gmii_tx_er,
   input  logic        col,
   input  logic        crs,
   input  logic [7:0]  reg_addr,
   input  logic [31:0] reg_wdata,
   input  logic        reg_wr,
   input  logic        reg_rd,
   output logic [31:0] reg_rdata,
   output logic        irq
);

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_next

   function automatic logic [7:0] pause_byte(input logic [4:0] idx, input logic [15:0] ptime);
      logic [143:0] f;
      f = {`PAUSE_DA, SRC_MAC, `PAUSE_TYPE, `PAUSE_OPCODE, ptime} << {idx, 3'b000};
      return f[143:136];
   endfunction : pause_byte

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   tx_app_pkg::tx_state_type state_reg;
   tx_app_pkg::tx_state_type state_next;
   logic [3:0]          sub_reg;
   logic [13:0]         cnt_reg;
   logic [31:0]         crc_reg;
   logic [7:0]          hi_reg;
   logic                last_reg;
   logic                pause_sel_reg;
   logic                ctrl_frm_reg;
   logic                pause_pend_reg;
   logic                pause_req_d_reg;
   logic [15:0]         ptime_reg;
   logic                under_reg;
   logic                mc_reg;
   logic                bc_reg;
   logic                vlan_hi_reg;
   logic                vlan_reg;
   logic                col_d_reg;
   logic [3:0]          ecol_reg;
   logic                late_reg;
   logic                xcol_reg;
   logic                defer_reg;
   logic                xdefer_reg;
   logic [`DEFER_W-1:0] defer_cnt_reg;
   logic [`CTRL_W-1:0]  ctrl_reg;
   logic [`IRQ_W-1:0]   irq_stat_reg;
   logic [`IRQ_W-1:0]   irq_en_reg;
   logic [`SV_W-1:0]    stat_now;
   logic [7:0]          byte_val;
   logic                byte_on;
   logic                frame_byte;
   logic                rd_req;
   logic                end_data;
   logic                report;

   // ----------------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------------
   wire        tx_en_cfg   = ctrl_reg[`CTRL_TX_EN];
   wire        fcs_en      = ctrl_reg[`CTRL_FCS_EN];
   wire        half_dup    = ctrl_reg[`CTRL_HALF_DUP];
   wire        idle        = (state_reg == tx_app_pkg::S_IDLE);
   wire        start_pause = idle && tx_en_cfg && pause_pend_reg;
   wire        start_data  = idle && tx_en_cfg && !pause_pend_reg && fifo_avail;
   wire        start       = start_pause || start_data;
   wire        underrun    = rd_req && fifo_empty;
   wire        word_full   = (fifo_byte_en == `BOTH_BYTES);
   wire        count_byte  = frame_byte || (state_reg == tx_app_pkg::S_FCS);
   wire [13:0] cnt_plus    = cnt_reg + 14'h0001;
   wire [13:0] total       = count_byte ? cnt_plus : cnt_reg;
   wire [7:0]  pause_b     = pause_byte(cnt_reg[4:0], ptime_reg);
   wire [31:0] fcs_shift   = (~crc_reg) >> {sub_reg[1:0], 3'b000};
   wire        in_frame    = !idle && (state_reg != tx_app_pkg::S_DEFER) && (state_reg != tx_app_pkg::S_IFG);
   wire        col_rise    = half_dup && in_frame && col && !col_d_reg;
   wire        early_col   = col_rise && (cnt_reg < `SLOT_BYTES);
   wire        frame_err   = under_reg || late_reg || xcol_reg;
   wire        pause_rise  = pause_req && !pause_req_d_reg;

   // ----------------------------------------------------------------------------
   // transmit sequencer
   // ----------------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      byte_val   = 8'h00;
      byte_on    = 1'b0;
      frame_byte = 1'b0;
      rd_req     = 1'b0;
      end_data   = 1'b0;
      report     = 1'b0;
      case (state_reg)
         tx_app_pkg::S_IDLE: begin
            if (start) begin
               state_next = (half_dup && crs) ? tx_app_pkg::S_DEFER : tx_app_pkg::S_PREAM;
            end
         end
         tx_app_pkg::S_DEFER: begin
            if (!crs) begin
               state_next = tx_app_pkg::S_PREAM;
            end
         end
         tx_app_pkg::S_PREAM: begin
            byte_on  = 1'b1;
            byte_val = (sub_reg == `PRE_LAST) ? `SFD_BYTE : `PRE_BYTE;
            if (sub_reg == `PRE_LAST) begin
               state_next = tx_app_pkg::S_DATA;
               rd_req     = !pause_sel_reg;
            end
         end
         tx_app_pkg::S_DATA: begin
            byte_on    = 1'b1;
            frame_byte = 1'b1;
            if (pause_sel_reg) begin
               byte_val = pause_b;
               end_data = (cnt_reg == `PAUSE_LAST);
            end else if (!sub_reg[0]) begin
               byte_val = fifo_data[7:0];
               end_data = !word_full;
            end else begin
               byte_val = hi_reg;
               end_data = last_reg;
               rd_req   = !last_reg;
            end
         end
         tx_app_pkg::S_PAD: begin
            byte_on    = 1'b1;
            frame_byte = 1'b1;
            if (cnt_plus >= `MIN_FRAME) begin
               state_next = tx_app_pkg::S_FCS;
            end
         end
         tx_app_pkg::S_FCS: begin
            byte_on  = 1'b1;
            byte_val = fcs_shift[7:0];
            if (sub_reg == `FCS_LAST) begin
               state_next = tx_app_pkg::S_IFG;
               report     = 1'b1;
            end
         end
         tx_app_pkg::S_IFG: begin
            if (sub_reg == `IFG_LAST) begin
               state_next = tx_app_pkg::S_IDLE;
            end
         end
         default: begin
            state_next = tx_app_pkg::S_IDLE;
         end
      endcase
      if (end_data) begin
         if (!fcs_en) begin
            state_next = tx_app_pkg::S_IFG;
            report     = 1'b1;
         end else begin
            state_next = (cnt_plus < `MIN_FRAME) ? tx_app_pkg::S_PAD : tx_app_pkg::S_FCS;
         end
      end
      // an under-run skips padding: the frame goes straight to the fcs, or with fcs off to the gap, with a coded error
      if (underrun) begin
         state_next = fcs_en ? tx_app_pkg::S_FCS : tx_app_pkg::S_IFG;
         report     = !fcs_en;
      end
   end

   assign fifo_read = rd_req;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= tx_app_pkg::S_IDLE;
         sub_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         sub_reg   <= (state_next != state_reg) ? 4'h0 : sub_reg + 4'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // frame data path
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= 14'h0000;
         crc_reg  <= `CRC_INIT;
         hi_reg   <= 8'h00;
         last_reg <= 1'b0;
      end else begin
         if (start) begin
            cnt_reg <= 14'h0000;
            crc_reg <= `CRC_INIT;
         end else begin
            cnt_reg <= total;
            crc_reg <= frame_byte ? crc_next(crc_reg, byte_val) : crc_reg;
         end
         if (state_reg == tx_app_pkg::S_DATA && !sub_reg[0]) begin
            hi_reg   <= fifo_data[15:8];
            last_reg <= fifo_eof;
         end
      end
   end

   // the error flag also covers fcs bytes so the whole tail is coded bad
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gmii_txd   <= 8'h00;
         gmii_tx_en <= 1'b0;
         gmii_tx_er <= 1'b0;
      end else begin
         gmii_txd   <= byte_val;
         gmii_tx_en <= byte_on;
         gmii_tx_er <= byte_on && (under_reg || underrun);
      end
   end

   // ----------------------------------------------------------------------------
   // pause request and frame selection
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pause_req_d_reg <= 1'b0;
         pause_pend_reg  <= 1'b0;
         ptime_reg       <= 16'h0000;
         pause_sel_reg   <= 1'b0;
         ctrl_frm_reg    <= 1'b0;
      end else begin
         pause_req_d_reg <= pause_req;
         pause_pend_reg  <= pause_rise || (pause_pend_reg && !start_pause);
         if (pause_rise) begin
            ptime_reg <= pause_time;
         end
         if (start) begin
            pause_sel_reg <= start_pause;
            ctrl_frm_reg  <= start_data && fifo_ctrl;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // per-frame statistics
   // ----------------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         under_reg   <= 1'b0;
         mc_reg      <= 1'b0;
         bc_reg      <= 1'b0;
         vlan_hi_reg <= 1'b0;
         vlan_reg    <= 1'b0;
      end else if (start) begin
         under_reg   <= 1'b0;
         mc_reg      <= 1'b0;
         bc_reg      <= 1'b1;
         vlan_hi_reg <= 1'b0;
         vlan_reg    <= 1'b0;
      end else begin
         under_reg <= under_reg || underrun;
         if (frame_byte && cnt_reg == 14'h0000) begin
            mc_reg <= byte_val[0];
         end
         if (frame_byte && cnt_reg <= `DA_LAST) begin
            bc_reg <= bc_reg && (byte_val == `BYTE_ALL_ONES);
         end
         if (frame_byte && cnt_reg == `VLAN_POS_HI) begin
            vlan_hi_reg <= (byte_val == `VLAN_TAG_HI);
         end
         if (frame_byte && cnt_reg == `VLAN_POS_LO) begin
            vlan_reg <= vlan_hi_reg && (byte_val == `VLAN_TAG_LO);
         end
      end
   end

   // no retry buffer here: collisions are only counted and reported
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         col_d_reg     <= 1'b0;
         ecol_reg      <= 4'h0;
         late_reg      <= 1'b0;
         xcol_reg      <= 1'b0;
         defer_reg     <= 1'b0;
         xdefer_reg    <= 1'b0;
         defer_cnt_reg <= '0;
      end else begin
         col_d_reg <= col;
         if (start) begin
            ecol_reg      <= 4'h0;
            late_reg      <= 1'b0;
            xcol_reg      <= 1'b0;
            defer_reg     <= half_dup && crs;
            xdefer_reg    <= 1'b0;
            defer_cnt_reg <= '0;
         end else begin
            if (early_col && ecol_reg != `ECOL_MAX) begin
               ecol_reg <= ecol_reg + 4'h1;
            end
            xcol_reg <= xcol_reg || (early_col && ecol_reg == `ECOL_MAX - 4'h1);
            late_reg <= late_reg || (col_rise && !early_col);
            if (state_reg == tx_app_pkg::S_DEFER) begin
               defer_cnt_reg <= defer_cnt_reg + `DEFER_W'(1);
               xdefer_reg    <= xdefer_reg || (defer_cnt_reg == `DEFER_W'(`DEFER_CYCLES - 1));
            end
         end
      end
   end

   always_comb begin
      stat_now                                 = '0;
      stat_now[`SV_UNICAST]                    = !mc_reg;
      stat_now[`SV_MULTICAST]                  = mc_reg && !bc_reg;
      stat_now[`SV_BROADCAST]                  = mc_reg && bc_reg;
      stat_now[`SV_BAD_FCS]                    = under_reg || underrun;
      stat_now[`SV_JUMBO]                      = total > `JUMBO_BYTES;
      stat_now[`SV_UNDERRUN]                   = under_reg || underrun;
      stat_now[`SV_PAUSE]                      = pause_sel_reg || ctrl_frm_reg;
      stat_now[`SV_VLAN]                       = vlan_reg;
      stat_now[`SV_BYTES_HI:`SV_BYTES_LO]      = total;
      stat_now[`SV_DEFER]                      = defer_reg;
      stat_now[`SV_XDEFER]                     = xdefer_reg;
      stat_now[`SV_LATE_COL]                   = late_reg;
      stat_now[`SV_XCOL]                       = xcol_reg;
      stat_now[`SV_ECOL_HI:`SV_ECOL_LO]        = ecol_reg;
      stat_now[`SV_SHORT]                      = !fcs_en && (total < `MIN_FRAME);
   end

   wire report_err = frame_err || underrun;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_vec   <= '0;
         stat_valid <= 1'b0;
         tx_done    <= 1'b0;
         discard    <= 1'b0;
      end else begin
         if (report) begin
            stat_vec <= stat_now;
         end
         stat_valid <= report;
         tx_done    <= report && !report_err;
         discard    <= report && report_err;
      end
   end

   // ----------------------------------------------------------------------------
   // registers and interrupt
   // ----------------------------------------------------------------------------
   wire              wr_ctrl  = reg_wr && (reg_addr == `REG_CTRL);
   wire              wr_clear = reg_wr && (reg_addr == `REG_IRQ_CLEAR);
   wire              wr_en    = reg_wr && (reg_addr == `REG_IRQ_ENABLE);
   wire [`IRQ_W-1:0] irq_ev   = {stat_valid && stat_vec[`SV_PAUSE], stat_valid && stat_vec[`SV_UNDERRUN],
                                 discard, tx_done};
   wire [`IRQ_W-1:0] irq_clr  = wr_clear ? reg_wdata[`IRQ_W-1:0] : '0;
   wire [31:0]       rd_mux   = (reg_addr == `REG_CTRL)       ? {{(32-`CTRL_W){1'b0}}, ctrl_reg} :
                                (reg_addr == `REG_IRQ_STATUS) ? {{(32-`IRQ_W){1'b0}}, irq_stat_reg} :
                                (reg_addr == `REG_IRQ_ENABLE) ? {{(32-`IRQ_W){1'b0}}, irq_en_reg} :
                                (reg_addr == `REG_LAST_STAT)  ? {1'b0, stat_vec} : 32'h0000_0000;

   // a new event in the clearing cycle survives: set wins over clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg     <= `CTRL_RESET;
         irq_stat_reg <= '0;
         irq_en_reg   <= '0;
         reg_rdata    <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata[`CTRL_W-1:0];
         end
         if (wr_en) begin
            irq_en_reg <= reg_wdata[`IRQ_W-1:0];
         end
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
         reg_rdata    <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

endmodule : tx_app_if

// file: sim/tx_app_if_properties.sv
// port assertions for the transmit application interface
`timescale 1ns/1ps
module tx_app_if_properties (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        fifo_read,
   input wire logic        fifo_empty,
   input wire logic [30:0] stat_vec,
   input wire logic        stat_valid,
   input wire logic        tx_done,
   input wire logic        discard,
   input wire logic        gmii_tx_er
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire err = stat_vec[5] | stat_vec[24] | stat_vec[25];
   read_pulse_a: assert property (fifo_read |=> !fifo_read)
      else $error("read strobe longer than one cycle");
   underrun_err_a: assert property (fifo_read && fifo_empty |-> ##[1:4] gmii_tx_er)
      else $error("under-run not marked on the line");
   stat_pulse_a: assert property (stat_valid |=> !stat_valid)
      else $error("statistics qualifier too long");
   done_qual_a: assert property ((tx_done || discard) |-> stat_valid)
      else $error("frame end report without statistics");
   done_clean_a: assert property (tx_done |-> !err)
      else $error("done pulse on a failed frame");
   discard_err_a: assert property (stat_valid && err |-> discard && !tx_done)
      else $error("failed frame not discarded");
   underrun_fcs_a: assert property (stat_valid && stat_vec[5] |-> stat_vec[3])
      else $error("under-run frame not marked bad");
   short_flag_a: assert property (stat_valid && stat_vec[21:8] >= 14'h003C |-> !stat_vec[30])
      else $error("long frame flagged short");
   pad_len_a: assert property (stat_valid && !stat_vec[5] && !stat_vec[30] |-> stat_vec[21:8] >= 14'h003C)
      else $error("complete frame shorter than minimum");
   cover property (tx_done);
   cover property (discard);
   cover property (stat_valid && stat_vec[6]);
endmodule : tx_app_if_properties

// file: sim/fifo_model.sv
// user transmit fifo holding one frame at a time
`timescale 1ns/1ps
module fifo_model (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        fifo_read,
   input  wire logic        discard,
   input  wire logic        load,
   input  wire logic [13:0] len,
   input  wire logic [7:0]  stop_at,
   input  wire logic [15:0] rnd,
   input  wire logic        ctrl,
   output logic [15:0]      fifo_data,
   output logic [1:0]       fifo_byte_en,
   output logic             fifo_avail,
   output logic             fifo_eof,
   output logic             fifo_empty,
   output logic             fifo_ctrl
);
   logic [7:0] cnt, words;
   wire        last = (cnt + 8'h01) == words;
   assign fifo_avail = cnt < words;
   assign fifo_empty = cnt >= words || cnt >= stop_at;
   assign fifo_ctrl  = ctrl;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         words <= 8'h00;
         fifo_data <= 16'h0000;
         fifo_byte_en <= 2'b00;
         fifo_eof <= 1'b0;
      end else begin
         // idle bus keeps toggling so a stale word never passes for data
         fifo_data <= ~fifo_data;
         fifo_byte_en <= ~fifo_byte_en;
         fifo_eof <= 1'b0;
         if (load) begin
            cnt <= 8'h00;
            words <= 8'((len + 14'h0001) >> 1);
         end else if (discard) begin
            words <= cnt;
         end
         if (fifo_read) begin
            cnt <= cnt + 8'h01;
            fifo_data <= (cnt == 8'h00) ? {rnd[15:1], 1'b0} : rnd;
            fifo_byte_en <= (last && len[0]) ? 2'b01 : 2'b11;
            fifo_eof <= last;
         end
      end
   end
endmodule : fifo_model

// file: sim/testbench.sv
// self-checking bench for the transmit application interface
`timescale 1ns/1ps
module testbench;
   logic        mclk, rst_n, reg_wr, reg_rd, pause_req, load, rd_seen, pf, ctrl, hd, col, crs;
   logic        fifo_read, stat_valid, tx_done, discard, gmii_tx_en, gmii_tx_er, irq;
   logic        fifo_avail, fifo_eof, fifo_empty, fifo_ctrl;
   logic [1:0]  fifo_byte_en;
   logic [7:0]  reg_addr, gmii_txd, stop_at;
   logic [13:0] len;
   logic [15:0] fifo_data, pause_time, rnd;
   logic [30:0] stat_vec;
   logic [31:0] reg_wdata, reg_rdata;
   logic [31:0] rq[$];
   logic [62:0] sq[$];
   logic [13:0] lens[3] = '{14'h002D, 14'h003C, 14'h0065};
   int          errors, checks, cyc, bi, seed = 30358;
   tx_app_if dut (.*);
   fifo_model far (.*);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   // a read passes its expected value in d
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= !wr;
      if (!wr) rq.push_back(d);
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : bus
   task automatic frame(input logic [13:0] n, input logic [7:0] stop, input logic c, input logic [62:0] note);
      @(posedge mclk);
      len <= n;
      ctrl <= c;
      stop_at <= stop;
      load <= 1'b1;
      sq.push_back(note);
      @(posedge mclk);
      load <= 1'b0;
      while (sq.size() != 0) @(posedge mclk);
      repeat (16) @(posedge mclk);
   endtask : frame
   always @(posedge mclk) begin
      rd_seen <= reg_rd;
      bi <= gmii_tx_en ? bi + 1 : 0;
      rnd <= 16'($random(seed));
      // half duplex only: one collision early in the frame, carrier busy until a frame waits
      col <= hd && bi == 20;
      crs <= hd && !fifo_avail;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end
   always @(negedge mclk) begin
      if (rd_seen) cmp(reg_rdata, rq.pop_front());
      if (stat_valid) begin
         cmp(stat_vec & sq[0][61:31], sq[0][30:0]);
         cmp(tx_done, sq[0][62]);
         cmp(discard, !sq[0][62]);
         void'(sq.pop_front());
      end
      if (pf && bi == 24) cmp(gmii_txd, pause_time[15:8]);
      if (pf && bi == 25) cmp(gmii_txd, pause_time[7:0]);
   end
   initial begin
      {rst_n, reg_wr, reg_rd, pause_req, load, pf, ctrl, hd} = 8'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      len = 14'h0000;
      stop_at = 8'hFF;
      pause_time = 16'h0000;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h00, 32'h0000_0003);
      bus(1'b0, 8'h40, 32'h0000_0000);
      bus(1'b1, 8'h0C, 32'h0000_0001);
      bus(1'b0, 8'h0C, 32'h0000_0001);
      // short frames are padded to sixty bytes, fcs adds four
      foreach (lens[i])
         frame(lens[i], 8'hFF, 1'b0, {1'b1, 31'h7FFF_FFFF, 9'h000,
               (lens[i] < 14'h003C ? 14'h003C : lens[i]) + 14'h0004, 8'h01});
      @(negedge mclk);
      cmp(irq, 32'h0000_0001);
      bus(1'b0, 8'h04, 32'h0000_0001);
      bus(1'b1, 8'h08, 32'h0000_000F);
      frame(14'h0064, 8'h05, 1'b0, {1'b0, 31'h0000_0028, 31'h0000_0028});
      bus(1'b0, 8'h04, 32'h0000_0006);
      @(negedge mclk);
      cmp(irq, 32'h0000_0000);
      // fcs off: no padding, short control frame
      bus(1'b1, 8'h00, 32'h0000_0001);
      frame(14'h002D, 8'hFF, 1'b1, {1'b1, 31'h7FFF_FFFF, 9'h100, 14'h002D, 8'h41});
      hd <= 1'b1;
      bus(1'b1, 8'h00, 32'h0000_0007);
      frame(14'h003C, 8'hFF, 1'b0, {1'b1, 31'h7FFF_FFFF, 9'h011, 14'h0040, 8'h01});
      hd <= 1'b0;
      bus(1'b1, 8'h00, 32'h0000_0003);
      @(posedge mclk);
      pause_time <= 16'($random(seed));
      pause_req <= 1'b1;
      pf <= 1'b1;
      sq.push_back({1'b1, 31'h7FFF_FFFF, 9'h000, 14'h0040, 8'h42});
      repeat (3) @(posedge mclk);
      pause_req <= 1'b0;
      while (sq.size() != 0) @(posedge mclk);
      stop_test();
   end
endmodule : testbench
bind tx_app_if tx_app_if_properties chk (.*);
